/* rtl/psb_regs.sv */
// gigabit status, bypass control and error counter management registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE1] descrambler lock bit15, link active bit12
// [RULE2] lock error bit14, disconnect bit13 self-clear
// [RULE3] receive error bit11, transmit error bit10
// [RULE4] start delimiter bit9, end delimiter bit8
// [RULE5] carrier extension error flag in bit7
// [RULE6] legacy partner bit6, crossover error bit5
// [RULE7] control bit15 disables the line transmitter
// [RULE8] bits 14/13/12 bypass encoder, scrambler, descrambler
// [RULE9] bits 11/10 bypass receive/transmit coding path
// [RULE10] bit9 bypasses link fail inhibit timer
// [RULE11] sticky bit7 stops crossover at forced speed
// [RULE12] sticky bit6 disables legacy partner detection
// [RULE13] sticky bit5 disables pair swap correction
// [RULE14] sticky bit4 disables polarity inversion correction
// [RULE15] sticky bit3 honours advertised ability when one
// [RULE16] bit2 disables transmit pulse shaping filter
// [RULE17] sticky bit1 hands next pages to host
// [RULE18] host then exchanges pages, forces configuration
// [RULE19] receive error counter saturates, clears on read
// [RULE20] false carrier counter saturates, clears on read
// [RULE21] sticky bits survive soft reset when enabled
// [RULE22] flags latch on event, clear after read
module psb_regs
  import psb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        soft_reset,
  input  wire logic        sticky_reset_enable,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        descrambler_locked,
  input  wire logic        link_active,
  input  wire logic        legacy_partner_seen,
  input  wire logic        crossover_error_seen,
  input  wire logic        lock_error_event,
  input  wire logic        disconnect_event,
  input  wire logic        rx_error_event,
  input  wire logic        tx_error_event,
  input  wire logic        start_delimiter_error,
  input  wire logic        end_delimiter_error,
  input  wire logic        carrier_ext_error_event,
  input  wire logic        receive_error_event,
  input  wire logic        false_carrier_event,
  input  wire logic        speed_forced,
  input  wire logic        autoneg_enabled,
  input  wire logic        base_page_exchanged,
  output logic             transmit_disable,
  output logic             bypass_4b5b,
  output logic             bypass_scrambler,
  output logic             bypass_descrambler,
  output logic             bypass_pcs_receive,
  output logic             bypass_pcs_transmit,
  output logic             bypass_link_fail_inhibit_timer,
  output logic             auto_crossover_enable,
  output logic             legacy_detect_enable,
  output logic             pair_swap_correction_enable,
  output logic             polarity_correction_enable,
  output logic             parallel_detect_honour_ability,
  output logic             pulse_shaping_disable,
  output logic             auto_next_page_enable,
  output logic             host_next_page_control
);
  logic [15:0] control;
  logic [15:0] flags;
  logic [7:0]  rx_err_count;
  logic [7:0]  false_carrier_count;

  // address decode
  wire sel_status  = (reg_addr == ADDR_STATUS_EXT2);
  wire sel_control = (reg_addr == ADDR_BYPASS_CTRL);
  wire sel_rx_err  = (reg_addr == ADDR_RX_ERR_COUNT);
  wire sel_false   = (reg_addr == ADDR_FALSE_CARRIER);
  wire write_ctrl  = reg_write && sel_control;
  wire read_status = reg_read && sel_status;

  // self-clearing event flags, set wins over a read clear
  wire [15:0] flag_events = {1'b0, lock_error_event, disconnect_event, 1'b0,
                             rx_error_event, tx_error_event, start_delimiter_error,
                             end_delimiter_error, carrier_ext_error_event, 7'h00};
  wire [15:0] next_flags  = (read_status ? 16'h0000 : flags) | flag_events;  // [RULE22]

  // live status levels
  wire [15:0] status_live;
  assign status_live[ST_DESCR_LOCKED]   = descrambler_locked;  // [RULE1]
  assign status_live[ST_LINK_ACTIVE]    = link_active;  // [RULE1]
  assign status_live[ST_LEGACY_PARTNER] = legacy_partner_seen && legacy_detect_enable;  // [RULE6]
  assign status_live[ST_CROSSOVER_ERR]  = crossover_error_seen;  // [RULE6]
  assign status_live[14:13]             = 2'b00;
  assign status_live[11:7]              = 5'h00;
  assign status_live[4:0]               = 5'h00;
  wire [15:0] status_word = status_live | flags;

  // control register: write, or soft reset keeping sticky bits when sticky_reset_enable is set
  wire [15:0] soft_value   = sticky_reset_enable
                           ? ((control & BYPASS_STICKY) | (BYPASS_RESET & ~BYPASS_STICKY))
                           : BYPASS_RESET;  // [RULE21]
  wire [15:0] next_control = soft_reset ? soft_value
                           : write_ctrl ? (reg_wdata & BYPASS_WRITABLE) : control;

  // read data selection, unmapped reads as zero
  wire [15:0] read_value = sel_status  ? status_word
                         : sel_control ? control
                         : sel_rx_err  ? {8'h00, rx_err_count}
                         : sel_false   ? {8'h00, false_carrier_count}
                         : 16'h0000;

  // next page hand-back to the host after the base page
  wire next_host_np = control[BC_NEXT_PAGE_DIS]
                    && (host_next_page_control || base_page_exchanged);  // [RULE17]

  // register state
  always_ff @(posedge clock) begin
    if (reset) begin
      control                <= BYPASS_RESET;
      flags                  <= STATUS_RESET;
      reg_rdata              <= 16'h0000;
      reg_rvalid             <= 1'b0;
      host_next_page_control <= 1'b0;
    end else begin
      control                <= next_control;
      flags                  <= next_flags;  // [RULE2] [RULE3] [RULE4] [RULE5]
      reg_rdata              <= reg_read ? read_value : reg_rdata;
      reg_rvalid             <= reg_read;
      host_next_page_control <= next_host_np;
    end
  end

  // error counters
  psb_sat_counter #(.WIDTH(COUNT_WIDTH)) u_rx_err (
    .clock       (clock),
    .reset       (reset),
    .count_event (receive_error_event),
    .read_clear  (reg_read && sel_rx_err),  // [RULE19]
    .count       (rx_err_count)
  );
  psb_sat_counter #(.WIDTH(COUNT_WIDTH)) u_false_carrier (
    .clock       (clock),
    .reset       (reset),
    .count_event (false_carrier_event),
    .read_clear  (reg_read && sel_false),  // [RULE20]
    .count       (false_carrier_count)
  );

  // control outputs to the line datapath
  assign transmit_disable               = control[BC_TX_DISABLE];  // [RULE7]
  assign bypass_4b5b                    = control[BC_BYPASS_4B5B];  // [RULE8]
  assign bypass_scrambler               = control[BC_BYPASS_SCRAM];  // [RULE8]
  assign bypass_descrambler             = control[BC_BYPASS_DESCRAM];  // [RULE8]
  assign bypass_pcs_receive             = control[BC_BYPASS_PCS_RX];  // [RULE9]
  assign bypass_pcs_transmit            = control[BC_BYPASS_PCS_TX];  // [RULE9]
  assign bypass_link_fail_inhibit_timer = control[BC_BYPASS_INHIBIT];  // [RULE10]
  assign auto_crossover_enable          = !(control[BC_XOVER_FORCED] && speed_forced);  // [RULE11]
  assign legacy_detect_enable           = !control[BC_LEGACY_DIS];  // [RULE12]
  assign pair_swap_correction_enable    = autoneg_enabled && !control[BC_PAIR_SWAP_DIS];  // [RULE13]
  assign polarity_correction_enable     = !control[BC_POLARITY_DIS];  // [RULE14]
  assign parallel_detect_honour_ability = control[BC_PARALLEL_DET];  // [RULE15]
  assign pulse_shaping_disable          = control[BC_PULSE_SHAPE_DIS];  // [RULE16]
  assign auto_next_page_enable          = !control[BC_NEXT_PAGE_DIS];  // [RULE17]

  // checks
  property p_ctrl_write;
    @(posedge clock) disable iff (reset)
      (write_ctrl && !soft_reset) |=> (control == ($past(reg_wdata) & BYPASS_WRITABLE));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");  // [RULE7]

  property p_tx_disable;
    @(posedge clock) disable iff (reset)
      (write_ctrl && !soft_reset && reg_wdata[BC_TX_DISABLE]) |=> transmit_disable;
  endproperty
  a_tx_disable: assert property (p_tx_disable) else $error("transmitter not disabled");  // [RULE7]

  property p_bypass_outputs;
    @(posedge clock) disable iff (reset)
      (write_ctrl && !soft_reset) |=>
        ({bypass_4b5b, bypass_scrambler, bypass_descrambler, bypass_pcs_receive,
          bypass_pcs_transmit, bypass_link_fail_inhibit_timer} == $past(reg_wdata[14:9]));
  endproperty
  a_bypass_outputs: assert property (p_bypass_outputs) else $error("bypass bits wrong");  // [RULE8]

  property p_soft_keep;
    @(posedge clock) disable iff (reset)
      (soft_reset && sticky_reset_enable) |=>
        ((control & BYPASS_STICKY) == ($past(control) & BYPASS_STICKY))
        && ((control & ~BYPASS_STICKY) == (BYPASS_RESET & ~BYPASS_STICKY));
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("sticky bits lost on soft reset");  // [RULE21]

  property p_soft_default;
    @(posedge clock) disable iff (reset)
      (soft_reset && !sticky_reset_enable) |=> (control == BYPASS_RESET);
  endproperty
  a_soft_default: assert property (p_soft_default) else $error("soft reset kept bits");  // [RULE21]

  property p_flag_hold;
    @(posedge clock) disable iff (reset)
      (lock_error_event && !read_status) ##1 !read_status |=> flags[ST_LOCK_ERROR];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("lock error flag dropped");  // [RULE2]

  property p_flag_clear;
    @(posedge clock) disable iff (reset)
      read_status |=> (flags == $past(flag_events));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by read");  // [RULE22]

  property p_read_answer;
    @(posedge clock) disable iff (reset)
      reg_read |=> (reg_rvalid && reg_rdata == $past(read_value));
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");  // [RULE1]

  property p_crossover;
    @(posedge clock) disable iff (reset)
      (control[BC_XOVER_FORCED] && speed_forced) |-> !auto_crossover_enable;
  endproperty
  a_crossover: assert property (p_crossover) else $error("crossover not disabled");  // [RULE11]

  property p_next_page;
    @(posedge clock) disable iff (reset)
      (control[BC_NEXT_PAGE_DIS] && base_page_exchanged && !soft_reset && !write_ctrl)
        |=> host_next_page_control;
  endproperty
  a_next_page: assert property (p_next_page) else $error("next page not handed back");  // [RULE17]

  property p_flag_set_wins;
    @(posedge clock) disable iff (reset)
      (read_status && carrier_ext_error_event) |=> flags[ST_CARRIER_EXT];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag lost");  // [RULE22]

  property p_rvalid_pulse;
    @(posedge clock) disable iff (reset)
      !reg_read |=> !reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("stray answer");  // [RULE1]

  property p_next_page_drop;
    @(posedge clock) disable iff (reset)
      !control[BC_NEXT_PAGE_DIS] |=> !host_next_page_control;
  endproperty
  a_next_page_drop: assert property (p_next_page_drop) else $error("pages kept");  // [RULE17]

  property p_reserved_zero;
    @(posedge clock) disable iff (reset)
      (control & ~BYPASS_WRITABLE) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");  // [RULE7]

  c_flag_read: cover property (@(posedge clock) disable iff (reset)
    read_status && flags[ST_RX_ERROR]);
  c_soft_sticky: cover property (@(posedge clock) disable iff (reset)
    soft_reset && sticky_reset_enable && !control[BC_XOVER_FORCED]);
  c_host_np: cover property (@(posedge clock) disable iff (reset) host_next_page_control);
endmodule
`default_nettype wire

/* rtl/psb_pkg.sv */
// constants for the gigabit status, bypass control and error counter registers
package psb_pkg;
  // register addresses on the management port
  localparam logic [4:0]  ADDR_STATUS_EXT2   = 5'h11;
  localparam logic [4:0]  ADDR_BYPASS_CTRL   = 5'h12;
  localparam logic [4:0]  ADDR_RX_ERR_COUNT  = 5'h13;
  localparam logic [4:0]  ADDR_FALSE_CARRIER = 5'h14;
  // status extension bit positions
  localparam int          ST_DESCR_LOCKED    = 15;
  localparam int          ST_LOCK_ERROR      = 14;
  localparam int          ST_DISCONNECT      = 13;
  localparam int          ST_LINK_ACTIVE     = 12;
  localparam int          ST_RX_ERROR        = 11;
  localparam int          ST_TX_ERROR        = 10;
  localparam int          ST_START_DELIM     = 9;
  localparam int          ST_END_DELIM       = 8;
  localparam int          ST_CARRIER_EXT     = 7;
  localparam int          ST_LEGACY_PARTNER  = 6;
  localparam int          ST_CROSSOVER_ERR   = 5;
  // bypass control bit positions
  localparam int          BC_TX_DISABLE      = 15;
  localparam int          BC_BYPASS_4B5B     = 14;
  localparam int          BC_BYPASS_SCRAM    = 13;
  localparam int          BC_BYPASS_DESCRAM  = 12;
  localparam int          BC_BYPASS_PCS_RX   = 11;
  localparam int          BC_BYPASS_PCS_TX   = 10;
  localparam int          BC_BYPASS_INHIBIT  = 9;
  localparam int          BC_XOVER_FORCED    = 7;
  localparam int          BC_LEGACY_DIS      = 6;
  localparam int          BC_PAIR_SWAP_DIS   = 5;
  localparam int          BC_POLARITY_DIS    = 4;
  localparam int          BC_PARALLEL_DET    = 3;
  localparam int          BC_PULSE_SHAPE_DIS = 2;
  localparam int          BC_NEXT_PAGE_DIS   = 1;
  // reset values and masks
  localparam logic [15:0] BYPASS_RESET       = 16'h0088;
  localparam logic [15:0] BYPASS_WRITABLE    = 16'hFEFE;
  localparam logic [15:0] BYPASS_STICKY      = 16'h00FA;
  localparam logic [15:0] STATUS_RESET       = 16'h0000;
  localparam int          COUNT_WIDTH        = 8;
endpackage

/* rtl/psb_sat_counter.sv */
// saturating event counter that clears when read
`timescale 1ns/1ps
`default_nettype none
module psb_sat_counter
  import psb_pkg::*;
#(
  parameter int WIDTH = COUNT_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             count_event,
  input  wire logic             read_clear,
  output logic [WIDTH-1:0]      count
);
  wire              at_max = (count == {WIDTH{1'b1}});
  wire  [WIDTH-1:0] next_count;

  // a read clears; an event in the read cycle is kept as one
  assign next_count = read_clear ? {{(WIDTH-1){1'b0}}, count_event}
                    : (count_event && !at_max) ? count + 1'b1 : count;

  // counter register
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // saturation holds the top value
  property p_saturate;
    @(posedge clock) disable iff (reset)
      (at_max && !read_clear) |=> (count == {WIDTH{1'b1}});
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter left saturation");  // [RULE19]

  // read clears unless an event coincides
  property p_read_clear;
    @(posedge clock) disable iff (reset)
      read_clear |=> (count == {{(WIDTH-1){1'b0}}, $past(count_event)});
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("counter not cleared on read");  // [RULE20]

  // counting below the top adds one
  property p_increment;
    @(posedge clock) disable iff (reset)
      (count_event && !read_clear && !at_max) |=> (count == $past(count) + 1'b1);
  endproperty
  a_increment: assert property (p_increment) else $error("counter missed an event");  // [RULE19]

  c_saturated: cover property (@(posedge clock) disable iff (reset) at_max);
endmodule
`default_nettype wire

/* test/psb_host_model.sv */
// management host model on the register strobe port
`timescale 1ns/1ps
`default_nettype none
module psb_host_model (
  input  wire logic        clock,
  output logic [4:0]       reg_addr,
  output logic             reg_write,
  output logic             reg_read,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // strobes idle from time zero
  initial begin
    reg_addr  = 5'h1F;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_wdata = 16'h0000;
  end
  // one-cycle write, also used to force the resolved setup
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_addr  <= ~a; // released lines show no stale value
    reg_wdata <= ~d;
  endtask
  // one-cycle read, answer taken in the cycle after the strobe edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

/* test/test_psb_regs.sv */
// self-checking bench for the management register group
`timescale 1ns/1ps
`default_nettype none
module test_psb_regs
  import psb_pkg::*;
();
  logic        clock, reset, soft_reset, sticky_reset_enable, speed_forced;
  logic        autoneg_enabled, base_page_exchanged, receive_error_event, false_carrier_event;
  logic [6:0]  ev;
  logic [3:0]  lv;
  wire logic [4:0]  reg_addr;
  wire logic [15:0] reg_wdata, reg_rdata;
  wire logic        reg_write, reg_read, reg_rvalid, transmit_disable, bypass_4b5b;
  wire logic        bypass_scrambler, bypass_descrambler, bypass_pcs_receive, bypass_pcs_transmit;
  wire logic        bypass_link_fail_inhibit_timer, auto_crossover_enable, legacy_detect_enable;
  wire logic        pair_swap_correction_enable, polarity_correction_enable, pulse_shaping_disable;
  wire logic        parallel_detect_honour_ability, auto_next_page_enable, host_next_page_control;
  int               n_fail = 0;
  int               n_compared = 0;
  int               n_cycles = 0;
  int               fpos[7] = '{14, 13, 11, 10, 9, 8, 7};
  // grouped control outputs
  wire logic [7:0]  paths = {transmit_disable, bypass_4b5b, bypass_scrambler, bypass_descrambler,
    bypass_pcs_receive, bypass_pcs_transmit, bypass_link_fail_inhibit_timer, pulse_shaping_disable};
  wire logic [3:0]  feats = {legacy_detect_enable, pair_swap_correction_enable,
    polarity_correction_enable, auto_next_page_enable};

  psb_host_model i_host (.clock, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
    .reg_rvalid);
  psb_regs i_dut (.clock, .reset, .soft_reset, .sticky_reset_enable, .reg_addr, .reg_write,
    .reg_read, .reg_wdata, .reg_rdata, .reg_rvalid, .descrambler_locked(lv[3]),
    .link_active(lv[2]), .legacy_partner_seen(lv[1]), .crossover_error_seen(lv[0]),
    .lock_error_event(ev[0]), .disconnect_event(ev[1]), .rx_error_event(ev[2]),
    .tx_error_event(ev[3]), .start_delimiter_error(ev[4]), .end_delimiter_error(ev[5]),
    .carrier_ext_error_event(ev[6]), .receive_error_event, .false_carrier_event, .speed_forced,
    .autoneg_enabled, .base_page_exchanged, .transmit_disable, .bypass_4b5b, .bypass_scrambler,
    .bypass_descrambler, .bypass_pcs_receive, .bypass_pcs_transmit,
    .bypass_link_fail_inhibit_timer, .auto_crossover_enable, .legacy_detect_enable,
    .pair_swap_correction_enable, .polarity_correction_enable, .parallel_detect_honour_ability,
    .pulse_shaping_disable, .auto_next_page_enable, .host_next_page_control);

  // clock and hang guard
  initial clock = 1'b0;
  always #25 clock = ~clock;
  always @(posedge clock) begin
    n_cycles <= n_cycles + 1;
    if (n_cycles == 3000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rdc(string what, logic [4:0] a, logic [15:0] e);
    logic [15:0] d;
    i_host.rd(a, d);
    chk(what, e, d);
  endtask
  task automatic ticks(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // reset values of every register and of every output except host_next_page_control
  task automatic t_defaults();
    rdc("status", ADDR_STATUS_EXT2, STATUS_RESET);
    rdc("control", ADDR_BYPASS_CTRL, BYPASS_RESET);
    rdc("rx count", ADDR_RX_ERR_COUNT, 16'h0000);
    rdc("fc count", ADDR_FALSE_CARRIER, 16'h0000);
    rdc("unmapped", 5'h00, 16'h0000);
    chk("paths", 16'h0000, {8'h00, paths});
    chk("features", 16'h000F, {12'h000, feats});
    chk("parallel", 16'h0001, {15'h0000, parallel_detect_honour_ability});
    chk("crossover", 16'h0000, {15'h0000, auto_crossover_enable});
  endtask
  // every control bit set, then cleared
  task automatic t_control();
    i_host.wr(ADDR_BYPASS_CTRL, 16'hFFFF);
    rdc("control all", ADDR_BYPASS_CTRL, BYPASS_WRITABLE);
    chk("paths on", 16'h00FF, {8'h00, paths});
    chk("features off", 16'h0000, {12'h000, feats});
    @(posedge clock);
    speed_forced <= 1'b0;
    ticks(1);
    chk("crossover free", 16'h0001, {15'h0000, auto_crossover_enable});
    i_host.wr(ADDR_BYPASS_CTRL, 16'h0000);
    speed_forced    <= 1'b1;
    autoneg_enabled <= 1'b0;
    rdc("control none", ADDR_BYPASS_CTRL, 16'h0000);
    chk("paths off", 16'h0000, {8'h00, paths});
    chk("features no aneg", 16'h000B, {12'h000, feats});
    chk("parallel off", 16'h0000, {15'h0000, parallel_detect_honour_ability});
    chk("crossover on", 16'h0001, {15'h0000, auto_crossover_enable});
    @(posedge clock);
    autoneg_enabled <= 1'b1;
  endtask
  // each self-clearing flag, live bits, legacy masking
  task automatic t_flags();
    i_host.wr(ADDR_STATUS_EXT2, 16'hFFFF);
    rdc("status ro", ADDR_STATUS_EXT2, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      ev <= 7'h01 << i;
      @(posedge clock);
      ev <= 7'h00;
      rdc("flag", ADDR_STATUS_EXT2, 16'h0001 << fpos[i]);
      rdc("flag clear", ADDR_STATUS_EXT2, 16'h0000);
    end
    // event on the very edge of a read: the set must win
    fork
      rdc("flag set wins", ADDR_STATUS_EXT2, 16'h0000);
      begin
        @(posedge clock);
        ev <= 7'h40;
        @(posedge clock);
        ev <= 7'h00;
      end
    join
    rdc("flag kept", ADDR_STATUS_EXT2, 16'h0080);
    @(posedge clock);
    lv <= 4'hF;
    rdc("live", ADDR_STATUS_EXT2, 16'h9060);
    i_host.wr(ADDR_BYPASS_CTRL, BYPASS_RESET | 16'h0040);
    rdc("live masked", ADDR_STATUS_EXT2, 16'h9020);
    chk("legacy off", 16'h0007, {12'h000, feats});
    @(posedge clock);
    lv <= 4'h0;
  endtask
  // saturation and clear on read
  task automatic t_counters();
    @(posedge clock);
    receive_error_event <= 1'b1;
    repeat (300) @(posedge clock);
    receive_error_event <= 1'b0;
    rdc("rx sat", ADDR_RX_ERR_COUNT, 16'h00FF);
    rdc("rx clear", ADDR_RX_ERR_COUNT, 16'h0000);
    @(posedge clock);
    false_carrier_event <= 1'b1;
    repeat (5) @(posedge clock);
    false_carrier_event <= 1'b0;
    rdc("fc five", ADDR_FALSE_CARRIER, 16'h0005);
    rdc("fc clear", ADDR_FALSE_CARRIER, 16'h0000);
  endtask
  // soft reset with and without sticky retention, then a hard reset
  task automatic t_soft();
    logic [15:0] keep;
    keep = (16'hFE76 & BYPASS_STICKY) | (BYPASS_RESET & ~BYPASS_STICKY);
    for (int k = 1; k >= 0; k--) begin
      i_host.wr(ADDR_BYPASS_CTRL, 16'hFE76);
      sticky_reset_enable <= k[0];
      soft_reset          <= 1'b1;
      @(posedge clock);
      soft_reset <= 1'b0;
      rdc("soft reset", ADDR_BYPASS_CTRL, k ? keep : BYPASS_RESET);
    end
    // mixed pattern, so a swapped bit shows, then state for the hard reset to clear
    i_host.wr(ADDR_BYPASS_CTRL, 16'hA956);
    rdc("mixed", ADDR_BYPASS_CTRL, 16'hA856);
    chk("paths mixed", 16'h00A9, {8'h00, paths});
    chk("features mixed", 16'h0004, {12'h000, feats});
    @(posedge clock);
    ev                  <= 7'h40;
    receive_error_event <= 1'b1;
    @(posedge clock);
    ev                  <= 7'h00;
    receive_error_event <= 1'b0;
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    rdc("hard reset", ADDR_BYPASS_CTRL, BYPASS_RESET);
    rdc("hard status", ADDR_STATUS_EXT2, STATUS_RESET);
    rdc("hard rx count", ADDR_RX_ERR_COUNT, 16'h0000);
    chk("hard paths", 16'h0000, {8'h00, paths});
  endtask
  // next pages handed to the host after the base page
  task automatic t_pages();
    i_host.wr(ADDR_BYPASS_CTRL, BYPASS_RESET | 16'h0002);
    ticks(1);
    chk("auto pages", 16'h0000, {15'h0000, auto_next_page_enable});
    chk("host early", 16'h0000, {15'h0000, host_next_page_control});
    @(posedge clock);
    base_page_exchanged <= 1'b1;
    @(posedge clock);
    base_page_exchanged <= 1'b0;
    ticks(1);
    chk("host pages", 16'h0001, {15'h0000, host_next_page_control});
    i_host.wr(ADDR_BYPASS_CTRL, BYPASS_RESET);
    ticks(1);
    chk("host done", 16'h0000, {15'h0000, host_next_page_control});
  endtask
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {reset, speed_forced, autoneg_enabled} = 3'b111;
    {soft_reset, sticky_reset_enable, base_page_exchanged} = 3'b000;
    {receive_error_event, false_carrier_event, ev, lv} = 13'h0000;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_defaults();
    t_control();
    t_flags();
    t_counters();
    t_soft();
    t_pages();
    close_out();
  end
endmodule
`default_nettype wire
